// >>> core/pqr_regs.sv
// port queue base, failing address and parameter register bank
`timescale 1ns/100ps
module pqr_regs
  import pqr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire pqr_state_t port_state,
  input wire logic param_load,
  input wire pqr_param_t param_in,
  input wire pqr_fault_t fault_in,
  output logic [31:0] queue_block_base,
  output logic fail_addr_valid,
  output logic param_valid,
  output logic cluster_size_reserved,
  output logic [12:0] buffer_size,
  output logic arb_defeat,
  output logic ext_header,
  output logic [5:0] quiet_slot_count,
  output logic quiet_slot_illegal,
  output logic wr_refused,
  output logic irq
);
  logic [31:0] qbase_r;
  logic [31:0] fail_r;
  logic fail_valid_r;
  logic [31:0] param_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [31:0] rdata_r;
  logic refused_r;
  pqr_param_t prm;

  wire sel_qbase = reg_addr == OFF_QUEUE_BASE;
  wire sel_fail = reg_addr == OFF_FAIL_ADDR;
  wire sel_param = reg_addr == OFF_PARAMS;
  wire sel_stat = reg_addr == OFF_IRQ_STATUS;
  wire sel_mask = reg_addr == OFF_IRQ_MASK;
  wire sel_state = reg_addr == OFF_PORT_STATE;
  wire state_writable = port_state == PQR_DISABLED ||
                        port_state == PQR_DIS_MAINT;
  wire qbase_we = reg_wr && sel_qbase && state_writable;
  wire ro_write = reg_wr && (sel_fail || sel_param);
  wire refuse = (reg_wr && sel_qbase && !state_writable) || ro_write;
  wire any_fault = fault_in.data_structure_fault ||
                   fault_in.memory_system_fault ||
                   fault_in.buffer_mem_error;
  wire [IRQ_W-1:0] irq_evt = {fault_in.buffer_mem_error,
                              fault_in.memory_system_fault,
                              fault_in.data_structure_fault};
  wire [IRQ_W-1:0] irq_clr = (reg_wr && sel_stat) ?
                             reg_wdata[IRQ_W-1:0] : IRQ_ZERO;
  wire [IRQ_W-1:0] irq_stat_nxt = irq_evt | (irq_stat_r & ~irq_clr);
  wire valid_now = port_state != PQR_UNINIT;
  wire [31:0] param_rd = valid_now ? (param_r & PARAM_MASK) : ZERO_WORD;
  wire [31:0] rd_mux =
    sel_qbase ? (qbase_r & QBASE_MASK) :
    sel_fail ? fail_r :
    sel_param ? param_rd :
    sel_stat ? {{(32-IRQ_W){1'b0}}, irq_stat_r} :
    sel_mask ? {{(32-IRQ_W){1'b0}}, irq_mask_r} :
    sel_state ? {{30{1'b0}}, port_state} : ZERO_WORD;

  // queue base has no defined reset value; only written values are trusted
  always_ff @(posedge clock) begin
    if (qbase_we) begin
      qbase_r <= reg_wdata & QBASE_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fail_r <= ZERO_WORD;
      fail_valid_r <= 1'b0;
    end else if (any_fault) begin
      fail_r <= fault_in.addr;
      fail_valid_r <= 1'b1;
    end else if (port_state == PQR_UNINIT) begin
      fail_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      param_r <= ZERO_WORD;
    end else if (param_load) begin
      param_r <= param_in & PARAM_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= IRQ_ZERO;
      irq_mask_r <= IRQ_ZERO;
      rdata_r <= ZERO_WORD;
      refused_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (reg_wr && sel_mask) begin
        irq_mask_r <= reg_wdata[IRQ_W-1:0];
      end
      rdata_r <= reg_rd ? rd_mux : ZERO_WORD;
      refused_r <= refuse;
    end
  end

  assign prm = pqr_param_t'(param_r);
  assign reg_rdata = rdata_r;
  assign queue_block_base = qbase_r & QBASE_MASK;
  assign fail_addr_valid = fail_valid_r;
  assign param_valid = valid_now;
  assign cluster_size_reserved = valid_now &&
    ((prm.cluster_size_code & CSZ_RESERVED_BIT) != 3'h0);
  assign buffer_size = valid_now ? prm.buffer_size : 13'h0000;
  assign arb_defeat = valid_now && prm.arb_defeat;
  assign ext_header = valid_now && prm.ext_header;
  assign wr_refused = refused_r;
  assign irq = |(irq_stat_r & irq_mask_r);

  pqr_quiet_slot u_qs (
    .quiet_slot_select(prm.quiet_slot_select),
    .quiet_slot_count(quiet_slot_count),
    .quiet_slot_illegal(quiet_slot_illegal)
  );
endmodule : pqr_regs

// >>> pkg/pqr_pkg.sv
// package: register map, field layout and constants of the port queue regs
package pqr_pkg;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] OFF_QUEUE_BASE = 16'h00f0;
  localparam logic [ADDR_W-1:0] OFF_FAIL_ADDR = 16'h00f4;
  localparam logic [ADDR_W-1:0] OFF_PARAMS = 16'h00f8;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 16'h0100;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 16'h0104;
  localparam logic [ADDR_W-1:0] OFF_PORT_STATE = 16'h0108;
  localparam logic [31:0] QBASE_MASK = 32'h1fff_fe00;
  localparam logic [31:0] PARAM_MASK = 32'hffff_1fff;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int IRQ_W = 3;
  localparam int IRQ_DSF = 0;
  localparam int IRQ_MSF = 1;
  localparam int IRQ_PERR = 2;
  localparam logic [IRQ_W-1:0] IRQ_ZERO = 3'h0;
  localparam logic [2:0] QS_ILLEGAL = 3'h7;
  // link quiet slot count per code; the illegal code falls back to 7
  localparam logic [5:0] QS_COUNT [8] = '{
    6'h07, 6'h0a, 6'h0e, 6'h10, 6'h15, 6'h19, 6'h20, 6'h07
  };
  localparam logic [2:0] CSZ_RESERVED_BIT = 3'h4;
  typedef enum logic [1:0] {
    PQR_UNINIT = 2'b00,
    PQR_DISABLED = 2'b01,
    PQR_DIS_MAINT = 2'b10,
    PQR_ENABLED = 2'b11
  } pqr_state_t;
  typedef struct packed {
    logic [2:0] cluster_size_code;
    logic [12:0] buffer_size;
    logic [2:0] must_be_zero_bits;
    logic arb_defeat;
    logic ext_header;
    logic [2:0] quiet_slot_select;
    logic [7:0] port_number;
  } pqr_param_t;
  typedef struct packed {
    logic data_structure_fault;
    logic memory_system_fault;
    logic buffer_mem_error;
    logic [31:0] addr;
  } pqr_fault_t;
endpackage : pqr_pkg

// >>> core/pqr_quiet_slot.sv
// quiet slot code decoder: slot count and illegal-code flag outputs
`timescale 1ns/100ps
module pqr_quiet_slot
  import pqr_pkg::*;
(
  input wire logic [2:0] quiet_slot_select,
  output logic [5:0] quiet_slot_count,
  output logic quiet_slot_illegal
);
  assign quiet_slot_count = QS_COUNT[quiet_slot_select];
  assign quiet_slot_illegal = quiet_slot_select == QS_ILLEGAL;
endmodule : pqr_quiet_slot

// >>> sim/pqr_regs_props.sv
// checker: port-level relations of the port queue register bank
`timescale 1ns/100ps
module pqr_props import pqr_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire pqr_state_t port_state,
  input wire logic [31:0] queue_block_base,
  input wire logic wr_refused
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire ok = port_state inside {PQR_DISABLED, PQR_DIS_MAINT};
  wire wq = reg_wr && reg_addr == OFF_QUEUE_BASE;
  wire ro = reg_wr && reg_addr inside {OFF_FAIL_ADDR, OFF_PARAMS};
  wire rp = reg_rd && reg_addr == OFF_PARAMS;
  wire [31:0] wm = reg_wdata & QBASE_MASK;
  property p_qz; (queue_block_base & ~QBASE_MASK) == ZERO_WORD; endproperty
  a_qz: assert property (p_qz) else $error("stray base bits");
  property p_qw; wq && ok |=> queue_block_base == $past(wm); endproperty
  a_qw: assert property (p_qw) else $error("base write lost");
  property p_qr; wq && !ok |=> $stable(queue_block_base); endproperty
  a_qr: assert property (p_qr) else $error("base changed");
  property p_ro; ro || wq && !ok |=> wr_refused; endproperty
  a_ro: assert property (p_ro) else $error("no refusal");
  property p_nr; !(ro || wq && !ok) |=> !wr_refused; endproperty
  a_nr: assert property (p_nr) else $error("false refusal");
  property p_id; !reg_rd |=> reg_rdata == ZERO_WORD; endproperty
  a_id: assert property (p_id) else $error("idle data");
  property p_pz; rp |=> reg_rdata[15:13] == 3'h0; endproperty
  a_pz: assert property (p_pz) else $error("reserved bits set");
  property p_pu; rp && port_state == PQR_UNINIT |=> !reg_rdata; endproperty
  a_pu: assert property (p_pu) else $error("params in uninit");
  c_qw: cover property (wq && ok);
  c_qr: cover property (wq && !ok);
  c_ro: cover property (ro);
endmodule : pqr_props
bind pqr_regs pqr_props u_props (.*);

// >>> sim/port_queue_and_param_regs_test.sv
// testbench: register access sequences for the port queue regs
`timescale 1ns/100ps
module port_queue_and_param_regs_test import pqr_pkg::*;;
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, param_load = 0, irq;
  logic fail_addr_valid, param_valid, cluster_size_reserved, wr_refused;
  logic arb_defeat, ext_header, quiet_slot_illegal;
  logic [5:0] quiet_slot_count;
  logic [12:0] buffer_size;
  logic [15:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, queue_block_base;
  pqr_state_t port_state = PQR_UNINIT;
  pqr_param_t param_in = '0;
  pqr_fault_t fault_in = '0;
  logic [5:0] qs[8] = '{6'h07, 6'h0a, 6'h0e, 6'h10,
                        6'h15, 6'h19, 6'h20, 6'h07};
  logic [31:0] pv = '0;
  int err_total = 0, comparisons = 0, cyc = 0;
  pqr_regs dut (.*);
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      report_and_stop(1);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic io(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clock);
    {reg_wr, reg_rd} <= 2'h0;
    @(posedge clock);
    if (!w) begin
      chk(reg_rdata, d);
    end
  endtask : io
  task automatic report_and_stop(input int late);
    err_total += late;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'h1;
    param_in <= '1;
    param_load <= 1'h1;
    @(posedge clock);
    param_load <= 1'h0;
    io(0, OFF_PARAMS, ZERO_WORD);
    chk({param_valid, buffer_size}, '0);
    chk({arb_defeat, ext_header, cluster_size_reserved}, '0);
    for (int i = 0; i < 8; i++) begin
      param_in <= {i[2:0], 13'h1abc, 3'h7, i[1:0], i[2:0], 8'h5a};
      param_load <= 1'h1;
      port_state <= PQR_DISABLED;
      @(posedge clock);
      param_load <= 1'h0;
      pv = {i[2:0], 13'h1abc, 3'h0, i[1:0], i[2:0], 8'h5a};
      io(0, OFF_PARAMS, pv);
      chk({quiet_slot_count, quiet_slot_illegal}, {qs[i], i == 7});
      chk(cluster_size_reserved, i[2]);
      chk({arb_defeat, ext_header}, i[1:0]);
      chk({param_valid, buffer_size}, {1'h1, 13'h1abc});
    end
    io(1, OFF_QUEUE_BASE, '1);
    io(0, OFF_QUEUE_BASE, QBASE_MASK);
    port_state <= PQR_ENABLED;
    io(1, OFF_QUEUE_BASE, '0);
    chk(wr_refused, 1'h1);
    io(0, OFF_QUEUE_BASE, QBASE_MASK);
    port_state <= PQR_DIS_MAINT;
    io(1, OFF_QUEUE_BASE, 32'h0000_0200);
    chk(wr_refused, 1'h0);
    io(1, OFF_PARAMS, '0);
    chk(wr_refused, 1'h1);
    io(0, OFF_PARAMS, pv);
    io(0, OFF_QUEUE_BASE, 32'h0000_0200);
    chk(fail_addr_valid, 1'h0);
    fault_in <= {3'h4, 32'h8000_1234};
    @(posedge clock);
    fault_in <= '0;
    io(0, OFF_FAIL_ADDR, 32'h8000_1234);
    chk(fail_addr_valid, 1'h1);
    io(1, OFF_FAIL_ADDR, '0);
    chk(wr_refused, 1'h1);
    io(0, OFF_FAIL_ADDR, 32'h8000_1234);
    io(0, OFF_IRQ_STATUS, 32'h0000_0001);
    chk(irq, 1'h0);
    io(1, OFF_IRQ_MASK, 32'h0000_0007);
    chk(irq, 1'h1);
    io(1, OFF_IRQ_STATUS, 32'h0000_0001);
    chk(irq, 1'h0);
    reg_wr <= 1'h1;
    reg_addr <= OFF_IRQ_STATUS;
    reg_wdata <= 32'h0000_0002;
    fault_in <= {3'h2, 32'h0012_3400};
    @(posedge clock);
    reg_wr <= 1'h0;
    fault_in <= '0;
    io(0, OFF_IRQ_STATUS, 32'h0000_0002);
    io(0, OFF_FAIL_ADDR, 32'h0012_3400);
    chk(irq, 1'h1);
    io(0, 16'h0200, '0);
    rst_n <= 1'h0;
    @(posedge clock);
    chk({irq, fail_addr_valid}, 2'h0);
    rst_n <= 1'h1;
    io(0, OFF_IRQ_MASK, '0);
    io(0, OFF_QUEUE_BASE, 32'h0000_0200);
    report_and_stop(0);
  end
endmodule : port_queue_and_param_regs_test
